// *** inc/acc_map.svh ***
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
// register addresses on the special function register bus
`define ACC_CTRL0_ADDR 8'h9A
`define ACC_MODE0_ADDR 8'h9B
`define ACC_CTRL1_ADDR 8'h9D
`define ACC_MODE1_ADDR 8'h9E
// control register field positions
`define ACC_CTRL_ON_BIT 7
`define ACC_CTRL_RESULT_BIT 6
`define ACC_CTRL_RISE_BIT 5
`define ACC_CTRL_FALL_BIT 4
`define ACC_CTRL_HYP_HI 3
`define ACC_CTRL_HYP_LO 2
`define ACC_CTRL_HYN_HI 1
`define ACC_CTRL_HYN_LO 0
// mode register field positions
`define ACC_MODE_RISE_IE_BIT 5
`define ACC_MODE_FALL_IE_BIT 4
`define ACC_MODE_SPEED_HI 1
`define ACC_MODE_SPEED_LO 0
// reset values
`define ACC_CTRL_RESET 8'h00
`define ACC_MODE_RESET 8'h02
`endif

// *** inc/acc_pkg.sv ***
package acc_pkg;
	// response-time settings, fastest/highest current first
	typedef enum logic [1:0] {
		ACC_SPEED_FASTEST = 2'h0,
		ACC_SPEED_MID_FAST = 2'h1,
		ACC_SPEED_MID_SLOW = 2'h2,
		ACC_SPEED_SLOWEST = 2'h3
	} acc_speed_t;
	// hysteresis levels: off, 5 mV, 10 mV, 20 mV
	typedef enum logic [1:0] {
		ACC_HYST_OFF = 2'h0,
		ACC_HYST_5MV = 2'h1,
		ACC_HYST_10MV = 2'h2,
		ACC_HYST_20MV = 2'h3
	} acc_hyst_t;
endpackage : acc_pkg

// *** verilog/acc_channel.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
// one comparator channel: control and mode registers, flags, outputs
module acc_channel
	import acc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// register access, already decoded
	input wire logic ctrl_wr,
	input wire logic mode_wr,
	input wire logic [7:0] wdata,
	output logic [7:0] ctrl_rdata,
	output logic [7:0] mode_rdata,
	// analog core
	input wire logic core_result,
	output logic core_power_on,
	output acc_speed_t core_speed,
	output acc_hyst_t core_pos_hyst,
	output acc_hyst_t core_neg_hyst,
	// pin outputs and interrupt
	output logic pin_sync_out,
	output logic pin_async_out,
	output logic irq_req
);
	logic cmp_on_reg, cmp_on_next;
	logic [1:0] pos_hysteresis_sel_reg, pos_hysteresis_sel_next;
	logic [1:0] neg_hysteresis_sel_reg, neg_hysteresis_sel_next;
	logic rise_seen_flag_reg, rise_seen_flag_next;
	logic fall_seen_flag_reg, fall_seen_flag_next;
	logic rise_irq_allow_reg, rise_irq_allow_next;
	logic fall_irq_allow_reg, fall_irq_allow_next;
	logic [1:0] response_speed_sel_reg, response_speed_sel_next;
	logic result_q_reg, result_q_next;
	logic result_prev_reg, result_prev_next;
	logic cmp_result;
	logic rise_evt, fall_evt;
	// reset images of both registers, fields picked out below
	localparam logic [7:0] ctrl_reset_val = `ACC_CTRL_RESET;
	localparam logic [7:0] mode_reset_val = `ACC_MODE_RESET;

	// disabled core reads as low so no stray edges appear while off
	assign cmp_result = cmp_on_reg & core_result;
	assign rise_evt = result_q_reg & ~result_prev_reg;
	assign fall_evt = ~result_q_reg & result_prev_reg;

	// next-state for registers and edge history
	always_comb begin
		cmp_on_next = cmp_on_reg;
		pos_hysteresis_sel_next = pos_hysteresis_sel_reg;
		neg_hysteresis_sel_next = neg_hysteresis_sel_reg;
		rise_seen_flag_next = rise_seen_flag_reg;
		fall_seen_flag_next = fall_seen_flag_reg;
		rise_irq_allow_next = rise_irq_allow_reg;
		fall_irq_allow_next = fall_irq_allow_reg;
		response_speed_sel_next = response_speed_sel_reg;
		result_q_next = cmp_result;
		result_prev_next = result_q_reg;
		if (ctrl_wr) begin
			cmp_on_next = wdata[`ACC_CTRL_ON_BIT];
			pos_hysteresis_sel_next = wdata[`ACC_CTRL_HYP_HI:`ACC_CTRL_HYP_LO];
			neg_hysteresis_sel_next = wdata[`ACC_CTRL_HYN_HI:`ACC_CTRL_HYN_LO];
			// writes can only clear or hold flags; writing one is harmless
			rise_seen_flag_next = rise_seen_flag_reg & wdata[`ACC_CTRL_RISE_BIT];
			fall_seen_flag_next = fall_seen_flag_reg & wdata[`ACC_CTRL_FALL_BIT];
		end
		if (mode_wr) begin
			// bits 7:6 and 3:2 are not stored
			rise_irq_allow_next = wdata[`ACC_MODE_RISE_IE_BIT];
			fall_irq_allow_next = wdata[`ACC_MODE_FALL_IE_BIT];
			response_speed_sel_next = wdata[`ACC_MODE_SPEED_HI:`ACC_MODE_SPEED_LO];
		end
		// an edge in the clearing cycle wins over the clear
		if (rise_evt) begin
			rise_seen_flag_next = 1'b1;
		end
		if (fall_evt) begin
			fall_seen_flag_next = 1'b1;
		end
	end

	// register stage
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmp_on_reg <= ctrl_reset_val[`ACC_CTRL_ON_BIT];
			pos_hysteresis_sel_reg <= ctrl_reset_val[`ACC_CTRL_HYP_HI:`ACC_CTRL_HYP_LO];
			neg_hysteresis_sel_reg <= ctrl_reset_val[`ACC_CTRL_HYN_HI:`ACC_CTRL_HYN_LO];
			rise_seen_flag_reg <= ctrl_reset_val[`ACC_CTRL_RISE_BIT];
			fall_seen_flag_reg <= ctrl_reset_val[`ACC_CTRL_FALL_BIT];
			rise_irq_allow_reg <= mode_reset_val[`ACC_MODE_RISE_IE_BIT];
			fall_irq_allow_reg <= mode_reset_val[`ACC_MODE_FALL_IE_BIT];
			response_speed_sel_reg <= mode_reset_val[`ACC_MODE_SPEED_HI:`ACC_MODE_SPEED_LO];
			result_q_reg <= 1'b0;
			result_prev_reg <= 1'b0;
		end else begin
			cmp_on_reg <= cmp_on_next;
			pos_hysteresis_sel_reg <= pos_hysteresis_sel_next;
			neg_hysteresis_sel_reg <= neg_hysteresis_sel_next;
			rise_seen_flag_reg <= rise_seen_flag_next;
			fall_seen_flag_reg <= fall_seen_flag_next;
			rise_irq_allow_reg <= rise_irq_allow_next;
			fall_irq_allow_reg <= fall_irq_allow_next;
			response_speed_sel_reg <= response_speed_sel_next;
			result_q_reg <= result_q_next;
			result_prev_reg <= result_prev_next;
		end
	end

	// readback; result bit is live, not sampled
	always_comb begin
		ctrl_rdata = {cmp_on_reg, cmp_result, rise_seen_flag_reg, fall_seen_flag_reg,
			pos_hysteresis_sel_reg, neg_hysteresis_sel_reg};
		mode_rdata = {2'h0, rise_irq_allow_reg, fall_irq_allow_reg, 2'h0,
			response_speed_sel_reg};
	end

	// core controls and outputs
	assign core_power_on = cmp_on_reg;
	assign core_speed = acc_speed_t'(response_speed_sel_reg);
	assign core_pos_hyst = acc_hyst_t'(pos_hysteresis_sel_reg);
	assign core_neg_hyst = acc_hyst_t'(neg_hysteresis_sel_reg);
	assign pin_sync_out = result_q_reg;
	// pure gate path, keeps working with clock stopped
	assign pin_async_out = cmp_result;
	assign irq_req = (rise_seen_flag_reg & rise_irq_allow_reg)
		| (fall_seen_flag_reg & fall_irq_allow_reg);
endmodule : acc_channel
`default_nettype wire

// *** verilog/acc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.svh"
module acc_top
	import acc_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic resetn,
	// special function register bus
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// analog core results, channel 0 and 1
	input wire logic [1:0] core_result,
	// analog core controls
	output logic [1:0] core_power_on,
	output logic [3:0] core_speed,
	output logic [3:0] core_pos_hyst,
	output logic [3:0] core_neg_hyst,
	// crossbar outputs and interrupts
	output logic [1:0] pin_sync_out,
	output logic [1:0] pin_async_out,
	output logic [1:0] irq_req
);
	logic [1:0] ctrl_wr, mode_wr;
	logic [7:0] ctrl_rd [2];
	logic [7:0] mode_rd [2];
	acc_speed_t speed [2];
	acc_hyst_t pos_h [2];
	acc_hyst_t neg_h [2];

	// address decode, one channel per register pair
	assign ctrl_wr[0] = sfr_wr & (sfr_addr == `ACC_CTRL0_ADDR);
	assign mode_wr[0] = sfr_wr & (sfr_addr == `ACC_MODE0_ADDR);
	assign ctrl_wr[1] = sfr_wr & (sfr_addr == `ACC_CTRL1_ADDR);
	assign mode_wr[1] = sfr_wr & (sfr_addr == `ACC_MODE1_ADDR);

	// both channels identical
	for (genvar i = 0; i < 2; i++) begin : g_ch
		acc_channel u_ch (
			.clk(clk),
			.resetn(resetn),
			.ctrl_wr(ctrl_wr[i]),
			.mode_wr(mode_wr[i]),
			.wdata(sfr_wdata),
			.ctrl_rdata(ctrl_rd[i]),
			.mode_rdata(mode_rd[i]),
			.core_result(core_result[i]),
			.core_power_on(core_power_on[i]),
			.core_speed(speed[i]),
			.core_pos_hyst(pos_h[i]),
			.core_neg_hyst(neg_h[i]),
			.pin_sync_out(pin_sync_out[i]),
			.pin_async_out(pin_async_out[i]),
			.irq_req(irq_req[i])
		);
		assign core_speed[2*i+1:2*i] = speed[i];
		assign core_pos_hyst[2*i+1:2*i] = pos_h[i];
		assign core_neg_hyst[2*i+1:2*i] = neg_h[i];
	end

	// combinational read mux; unmapped addresses read zero
	always_comb begin
		case (sfr_addr)
			`ACC_CTRL0_ADDR: sfr_rdata = ctrl_rd[0];
			`ACC_MODE0_ADDR: sfr_rdata = mode_rd[0];
			`ACC_CTRL1_ADDR: sfr_rdata = ctrl_rd[1];
			`ACC_MODE1_ADDR: sfr_rdata = mode_rd[1];
			default: sfr_rdata = 8'h00;
		endcase
	end
endmodule : acc_top
`default_nettype wire

// *** tb/acc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// analog core stand-in, follows the bench level only while powered
module acc_core_model (
	// power from block, level from bench
	input wire logic [1:0] power_on,
	input wire logic [1:0] level,
	// result to block
	output logic [1:0] result
);
	// unpowered core shows the inverse, so a missing gate is seen
	assign result = (level & power_on) | (~level & ~power_on);
endmodule : acc_core_model
`default_nettype wire

// *** tb/acc_top_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// port relations: pins of both channels, registers and flags of channel 0
module acc_top_monitor (
	// clock, reset, bus
	input wire logic clk,
	input wire logic resetn,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic [7:0] sfr_rdata,
	// core and pins
	input wire logic [1:0] core_result,
	input wire logic [1:0] core_power_on,
	input wire logic [3:0] core_speed,
	input wire logic [3:0] core_pos_hyst,
	input wire logic [3:0] core_neg_hyst,
	input wire logic [1:0] pin_sync_out,
	input wire logic [1:0] pin_async_out,
	input wire logic [1:0] irq_req
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// flags are only visible while their register is addressed
	wire logic c0 = sfr_addr == 8'h9A;
	wire logic m0 = sfr_addr == 8'h9B;
	a_async_gate: assert property (pin_async_out == (core_result & core_power_on))
		else $error("async pin wrong");
	a_sync_flop: assert property (pin_sync_out == ($past(core_result) & $past(core_power_on)))
		else $error("sync pin wrong");
	a_rise_flag: assert property ($rose(pin_sync_out[0]) |=> (!c0 || sfr_rdata[5]))
		else $error("rise flag not set");
	a_fall_flag: assert property ($fell(pin_sync_out[0]) |=> (!c0 || sfr_rdata[4]))
		else $error("fall flag not set");
	a_flag_sticky: assert property ((c0 && sfr_rdata[5] && !sfr_wr) |=> (!c0 || sfr_rdata[5]))
		else $error("flag lost");
	a_mode_unused: assert property (m0 |-> (sfr_rdata & 8'hCC) == 8'h00)
		else $error("unused mode bits set");
	a_power_bit: assert property (c0 |-> sfr_rdata[7] == core_power_on[0])
		else $error("power bit wrong");
	a_hyst_map: assert property (c0 |-> sfr_rdata[3:0] == {core_pos_hyst[1:0], core_neg_hyst[1:0]})
		else $error("hysteresis wrong");
	a_speed_map: assert property (m0 |-> sfr_rdata[1:0] == core_speed[1:0])
		else $error("speed wrong");
	cover property ($rose(irq_req[0]));
	cover property ($rose(irq_req[1]));
	cover property ($fell(pin_sync_out[1]));
endmodule : acc_top_monitor
bind acc_top acc_top_monitor i_acc_top_monitor (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr),
	.sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .core_result(core_result),
	.core_power_on(core_power_on), .core_speed(core_speed), .core_pos_hyst(core_pos_hyst),
	.core_neg_hyst(core_neg_hyst), .pin_sync_out(pin_sync_out),
	.pin_async_out(pin_async_out), .irq_req(irq_req));
`default_nettype wire

// *** tb/acc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module acc_top_test;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [1:0] level = 2'h0;
	logic [7:0] sfr_rdata;
	logic [1:0] core_result, core_power_on, pin_sync_out, pin_async_out, irq_req;
	logic [3:0] core_speed, core_pos_hyst, core_neg_hyst;
	logic [31:0] seed = 32'hA2CE92FC;
	logic [7:0] md, hy, base;
	int err_total = 0;
	int compares = 0;
	int ch;
	always #25 clk = ~clk;
	acc_top i_acc_top (.clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .core_result(core_result),
		.core_power_on(core_power_on), .core_speed(core_speed), .core_pos_hyst(core_pos_hyst),
		.core_neg_hyst(core_neg_hyst), .pin_sync_out(pin_sync_out),
		.pin_async_out(pin_async_out), .irq_req(irq_req));
	acc_core_model i_acc_core_model (.power_on(core_power_on), .level(level), .result(core_result));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	// interrupt level expected from flag and enable bits
	function automatic logic [7:0] exp_irq(input logic [7:0] c, input logic [7:0] m);
		return {7'h0, (c[5] & m[5]) | (c[4] & m[4])};
	endfunction : exp_irq
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// strobe held across one rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge clk);
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk);
		sfr_addr = a;
		#1 chk(sfr_rdata, exp);
	endtask : rd
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : report_and_stop
	// watchdog, run needs well under 20 us
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (8) @(posedge clk);
		@(negedge clk);
		resetn = 1'b1;
		rd(8'h9A, 8'h00);
		rd(8'h9B, 8'h02);
		rd(8'h9D, 8'h00);
		rd(8'h9E, 8'h02);
		rd(8'h9C, 8'h00);
		for (int i = 0; i < 8; i++) begin
			ch = i % 2;
			base = (ch == 1) ? 8'h9D : 8'h9A;
			seed = lfsr(seed);
			md = (i < 2) ? 8'hFF : seed[7:0];
			hy = {4'h0, seed[11:8]};
			wr(base + 8'h01, md);
			rd(base + 8'h01, md & 8'h33);
			// bit 6 written high must not stick
			wr(base, 8'hC0 | hy);
			rd(base, 8'h80 | hy);
			chk({core_speed[ch*2 +: 2], core_pos_hyst[ch*2 +: 2], core_neg_hyst[ch*2 +: 2]}, {md[1:0], hy[3:0]});
			level[ch] = 1'b1;
			// unclocked pin follows at once, the registered one waits for an edge
			#1 chk({6'h0, pin_sync_out[ch], pin_async_out[ch]}, 8'h01);
			repeat (3) @(negedge clk);
			rd(base, 8'hE0 | hy);
			chk({6'h0, pin_sync_out[ch], pin_async_out[ch]}, 8'h03);
			chk({7'h0, irq_req[ch]}, exp_irq(8'h20, md));
			level[ch] = 1'b0;
			repeat (3) @(negedge clk);
			rd(base, 8'hB0 | hy);
			chk({7'h0, irq_req[ch]}, exp_irq(8'h30, md));
			wr(base, 8'h80 | hy);
			rd(base, 8'h80 | hy);
			chk({7'h0, irq_req[ch]}, 8'h00);
			// writing ones to the flags only holds them, never sets them
			wr(base, 8'hB0 | hy);
			rd(base, 8'h80 | hy);
			// rise lands in the cycle of the clearing write: set wins, fall not yet seen
			level[ch] = 1'b1;
			wr(base, hy);
			rd(base, 8'h20 | hy);
			chk({6'h0, pin_async_out[ch], core_power_on[ch]}, 8'h00);
			// unpowered core now shows high, pins must stay low
			level[ch] = 1'b0;
			#1 chk({6'h0, pin_sync_out[ch], pin_async_out[ch]}, 8'h00);
			$display("test %0d done", i);
		end
		report_and_stop();
	end
endmodule : acc_top_test
`default_nettype wire
